// [core/terminal_command_decoder.sv]
// Programmable terminal decoder: input terminals to drive commands,
// drive status to transistor and relay outputs, configured over APB.
// Assumes drive status inputs are synchronous to pclk; terminal pins are not.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "term_defines.svh"
module terminal_command_decoder #(
  parameter int TERMINALS = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [TERMINALS-1:0] terminal_pin,
  input wire logic keypad_run_key,
  input wire logic keypad_jog_combo,
  input wire logic protect_trip,
  input wire logic dc_braking,
  input wire logic [`FREQ_W-1:0] output_freq,
  input wire logic [`FREQ_W-1:0] set_freq,
  input wire logic [`FREQ_W-1:0] start_freq,
  output logic accel_set2_sel,
  output logic run_forward,
  output logic run_reverse,
  output logic decel_to_stop,
  output logic output_cut,
  output logic external_equipment_alarm,
  output logic alarm_output,
  output logic alarm_indication,
  output logic restart_permit,
  output logic jog_mode,
  output logic jog_run,
  output logic freq_cmd2_sel,
  output logic edit_all_permit,
  output logic edit_protect_only,
  output logic loop_enable,
  output logic inverse_freq,
  output logic loop_process_inverse,
  output logic comms_source_sel,
  output logic loop_terms_clear,
  output logic loop_integ_freeze,
  output logic transistor_output,
  output logic relay_output
);

  // ==========================================================
  // Elaboration check
  generate
    if (TERMINALS < 1 || TERMINALS > 5) begin : bad_terminals
      $error("terminal count must be 1 to 5");
    end
  endgenerate

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Functions
  // Returns {assigned, active} for one input function code
  function automatic logic [1:0] func_state(input logic [TERMINALS-1:0][`ASSIGN_W-1:0] asg,
                                            input logic [TERMINALS-1:0] lvl,
                                            input logic [6:0] code);
    logic [1:0] res;
    logic neg;
    logic [`ASSIGN_W-1:0] raw;
    res = 2'b00;
    for (int t = 0; t < TERMINALS; t++) begin
      neg = (asg[t] >= `NEG_LOGIC_OFFSET);
      raw = neg ? asg[t] - `NEG_LOGIC_OFFSET : asg[t];
      if (raw == {4'h0, code}) begin
        res[1] = 1'b1;
        res[0] = res[0] | (lvl[t] ^ neg);
      end
    end
    return res;
  endfunction : func_state

  // Unlisted output codes read inactive
  function automatic logic out_select(input logic [6:0] code, input logic moving,
                                      input logic match, input logic alarm);
    logic sel;
    sel = 1'b0;
    if (code == `OUT_CODE_MOVING) sel = moving;
    else if (code == `OUT_CODE_MATCH) sel = match;
    else if (code == `OUT_CODE_ALARM) sel = alarm;
    return sel;
  endfunction : out_select

  function automatic logic [`ASSIGN_W-1:0] assign_rst(input int t);
    logic [`ASSIGN_W-1:0] v;
    v = `ASSIGN_X1_RST;
    if (t == 1) v = `ASSIGN_X2_RST;
    else if (t == 2) v = `ASSIGN_X3_RST;
    else if (t == 3) v = `ASSIGN_FWD_RST;
    else if (t == 4) v = `ASSIGN_REV_RST;
    return v;
  endfunction : assign_rst

  // ==========================================================
  // Terminal synchronisation
  logic [TERMINALS-1:0] term_level;
  pin_sync #(.WIDTH(TERMINALS)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_async(terminal_pin),
    .pin_stable(term_level)
  );

  // ==========================================================
  // APB slave
  logic [TERMINALS-1:0][`ASSIGN_W-1:0] assign_reg;
  logic [3:0] config_reg;
  logic [15:0] out_assign_reg;
  logic [31:0] rd_word;
  logic rd_hit;
  logic apb_setup;
  logic apb_write;
  logic [5:0] word_idx;
  logic [31:0] cmd_status;
  logic [31:0] drive_status;

  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pready & pwrite;
  assign word_idx = paddr[7:2];

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = (paddr[1:0] == 2'h0) && (word_idx <= `LAST_WORD_IDX);
    for (int t = 0; t < TERMINALS; t++) begin
      if (paddr == 8'(`ASSIGN_BASE_OFS + 4 * t)) rd_word = {21'h0, assign_reg[t]};
    end
    if (paddr == `CONFIG_OFS) rd_word = {28'h0, config_reg};
    if (paddr == `OUT_ASSIGN_OFS) rd_word = {16'h0, out_assign_reg};
    if (paddr == `CMD_STATUS_OFS) rd_word = cmd_status;
    if (paddr == `DRIVE_STATUS_OFS) rd_word = drive_status;
  end

  // One wait-free access phase: pready rises the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~rd_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata <= (pwrite || !rd_hit) ? 32'h0000_0000 : rd_word;
    end
  end

  genvar g;
  generate
    for (g = 0; g < TERMINALS; g++) begin : g_assign
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          assign_reg[g] <= assign_rst(g);
        end else if (apb_write && paddr == 8'(`ASSIGN_BASE_OFS + 4 * g)) begin
          assign_reg[g] <= pwdata[`ASSIGN_W-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= `CONFIG_RST;
      out_assign_reg <= `OUT_ASSIGN_RST;
    end else if (apb_write) begin
      if (paddr == `CONFIG_OFS) config_reg <= pwdata[3:0];
      if (paddr == `OUT_ASSIGN_OFS) out_assign_reg <= pwdata[15:0];
    end
  end

  // ==========================================================
  // Input decoding
  logic [1:0] ramp_fs, latch_fs, coast_fs, reset_fs, ext_fs, inch_fs, freq_fs;
  logic [1:0] edit_fs, loop_fs, inv_fs, comms_fs, clr_fs, frz_fs, fwd_fs, rev_fs;
  assign ramp_fs = func_state(assign_reg, term_level, `CODE_RAMP_SET);
  assign latch_fs = func_state(assign_reg, term_level, `CODE_LATCH);
  assign coast_fs = func_state(assign_reg, term_level, `CODE_COAST);
  assign reset_fs = func_state(assign_reg, term_level, `CODE_ALARM_RESET);
  assign ext_fs = func_state(assign_reg, term_level, `CODE_EXT_FAULT);
  assign inch_fs = func_state(assign_reg, term_level, `CODE_INCH);
  assign freq_fs = func_state(assign_reg, term_level, `CODE_FREQ_SRC);
  assign edit_fs = func_state(assign_reg, term_level, `CODE_EDIT_PERMIT);
  assign loop_fs = func_state(assign_reg, term_level, `CODE_LOOP_EN);
  assign inv_fs = func_state(assign_reg, term_level, `CODE_INVERSE);
  assign comms_fs = func_state(assign_reg, term_level, `CODE_COMMS);
  assign clr_fs = func_state(assign_reg, term_level, `CODE_INTEG_CLEAR);
  assign frz_fs = func_state(assign_reg, term_level, `CODE_INTEG_FREEZE);
  assign fwd_fs = func_state(assign_reg, term_level, `CODE_FORWARD);
  assign rev_fs = func_state(assign_reg, term_level, `CODE_BACKWARD);

  logic [1:0] run_src;
  logic keypad_mode;
  logic edit_permit;
  assign run_src = config_reg[`CFG_RUN_SRC_LSB +: 2];
  assign keypad_mode = (run_src != `RUN_SRC_TERMINAL);
  assign edit_permit = edit_fs[1] ? edit_fs[0] : 1'b1;

  // ==========================================================
  // Simple level commands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accel_set2_sel <= 1'b0;
      freq_cmd2_sel <= 1'b0;
      edit_all_permit <= 1'b0;
      edit_protect_only <= 1'b0;
      loop_enable <= 1'b0;
      inverse_freq <= 1'b0;
      loop_process_inverse <= 1'b0;
      comms_source_sel <= 1'b0;
      loop_terms_clear <= 1'b0;
      loop_integ_freeze <= 1'b0;
    end else begin
      accel_set2_sel <= ramp_fs[0];
      freq_cmd2_sel <= freq_fs[0];
      edit_all_permit <= edit_permit & ~config_reg[`CFG_EDIT_PROTECT_BIT];
      edit_protect_only <= edit_permit & config_reg[`CFG_EDIT_PROTECT_BIT];
      loop_enable <= loop_fs[0];
      inverse_freq <= inv_fs[0];
      loop_process_inverse <= loop_fs[0] & (config_reg[`CFG_PROCESS_INV_BIT] ^ inv_fs[0]);
      comms_source_sel <= comms_fs[1] ? comms_fs[0] : 1'b1;
      loop_terms_clear <= clr_fs[0];
      loop_integ_freeze <= frz_fs[0];
    end
  end

  edit_lock_a: assert property (!edit_permit |=> !edit_all_permit && !edit_protect_only)
    else $error("edits allowed without permit");

  // ==========================================================
  // Status flags
  logic moving_reg;
  logic match_reg;
  logic [`FREQ_W-1:0] freq_diff;
  assign freq_diff = (output_freq >= set_freq) ? output_freq - set_freq : set_freq - output_freq;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      moving_reg <= 1'b0;
      match_reg <= 1'b0;
    end else begin
      moving_reg <= (output_freq > start_freq) & ~dc_braking;
      match_reg <= (freq_diff <= `MATCH_WINDOW);
    end
  end

  moving_brake_a: assert property (dc_braking |=> !moving_reg)
    else $error("moving flag set during braking");
  match_window_a: assert property ((freq_diff == `MATCH_WINDOW) |=> match_reg)
    else $error("speed match missed at window edge");
  match_outside_a: assert property ((freq_diff > `MATCH_WINDOW) |=> !match_reg)
    else $error("speed match set outside window");

  // ==========================================================
  // Alarm sequence
  term_pkg::alarm_state_t alarm_reg, alarm_next;
  logic ext_trip;
  logic any_trip;
  logic reset_active;
  assign ext_trip = ext_fs[1] & ~ext_fs[0] & moving_reg;
  assign any_trip = ext_trip | protect_trip;
  assign reset_active = reset_fs[0];

  // A new trip outranks a reset in the same cycle
  always_comb begin
    alarm_next = alarm_reg;
    unique case (alarm_reg)
      term_pkg::ALARM_NORMAL: if (any_trip) alarm_next = term_pkg::ALARM_TRIPPED;
      term_pkg::ALARM_TRIPPED: if (reset_active && !any_trip) alarm_next = term_pkg::ALARM_RESETTING;
      term_pkg::ALARM_RESETTING: begin
        if (any_trip) alarm_next = term_pkg::ALARM_TRIPPED;
        else if (!reset_active) alarm_next = term_pkg::ALARM_NORMAL;
      end
      default: alarm_next = term_pkg::ALARM_TRIPPED;
    endcase
  end

  // Short reset pulses are not filtered; a held reset is expected outside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_reg <= term_pkg::ALARM_NORMAL;
      alarm_output <= 1'b0;
      alarm_indication <= 1'b0;
      restart_permit <= 1'b0;
    end else begin
      alarm_reg <= alarm_next;
      alarm_output <= (alarm_next == term_pkg::ALARM_TRIPPED);
      alarm_indication <= (alarm_next != term_pkg::ALARM_NORMAL);
      restart_permit <= (alarm_next == term_pkg::ALARM_NORMAL);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_equipment_alarm <= 1'b0;
    end else if (ext_trip) begin
      external_equipment_alarm <= 1'b1;
    end else if (alarm_next == term_pkg::ALARM_NORMAL) begin
      external_equipment_alarm <= 1'b0;
    end
  end

  sequence s_reset_pressed;
    alarm_reg == term_pkg::ALARM_TRIPPED && reset_active && !any_trip;
  endsequence
  sequence s_reset_released;
    alarm_reg == term_pkg::ALARM_RESETTING && !reset_active && !any_trip;
  endsequence
  reset_clear_a: assert property (s_reset_pressed |=> !alarm_output && alarm_indication)
    else $error("alarm output not cleared by reset");
  reset_release_a: assert property (s_reset_released |=> restart_permit && !alarm_indication)
    else $error("indications kept after reset release");
  ext_fault_a: assert property (ext_trip |=> output_cut && external_equipment_alarm && alarm_output)
    else $error("external fault did not trip");

  // ==========================================================
  // Run, latch and cut
  logic run_fwd_next, run_rev_next, cut_next;
  logic fwd_lvl, rev_lvl;
  assign fwd_lvl = fwd_fs[0];
  assign rev_lvl = rev_fs[0];
  assign cut_next = coast_fs[0] | (alarm_next != term_pkg::ALARM_NORMAL);

  always_comb begin
    run_fwd_next = fwd_lvl & ~rev_lvl;
    run_rev_next = rev_lvl & ~fwd_lvl;
    if (latch_fs[1]) begin
      run_fwd_next = run_forward;
      run_rev_next = run_reverse;
      if (!latch_fs[0]) begin
        run_fwd_next = 1'b0;
        run_rev_next = 1'b0;
      end else if (fwd_lvl && !rev_lvl) begin
        run_fwd_next = 1'b1;
        run_rev_next = 1'b0;
      end else if (rev_lvl && !fwd_lvl) begin
        run_fwd_next = 1'b0;
        run_rev_next = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_forward <= 1'b0;
      run_reverse <= 1'b0;
      decel_to_stop <= 1'b0;
      output_cut <= 1'b0;
    end else begin
      run_forward <= run_fwd_next;
      run_reverse <= run_rev_next;
      decel_to_stop <= ~(run_fwd_next | run_rev_next) & ~cut_next;
      output_cut <= cut_next;
    end
  end

  latch_hold_a: assert property (latch_fs == 2'b11 && run_forward && !fwd_lvl && !rev_lvl |=> run_forward)
    else $error("three-wire latch lost run");
  latch_release_a: assert property (latch_fs == 2'b10 |=> !run_forward && !run_reverse)
    else $error("latch release kept run");
  coast_cut_a: assert property (coast_fs[0] && alarm_reg == term_pkg::ALARM_NORMAL && !any_trip
    |=> output_cut && !alarm_indication)
    else $error("coast stop wrong");
  stop_decel_a: assert property (!latch_fs[1] && !fwd_lvl && !rev_lvl |=> decel_to_stop || output_cut)
    else $error("no deceleration after run released");

  // ==========================================================
  // Jogging
  logic jog_toggle_reg;
  logic jog_mode_next;
  assign jog_mode_next = inch_fs[0] | (keypad_mode & jog_toggle_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jog_toggle_reg <= 1'b0;
    end else if (keypad_mode && !inch_fs[0] && keypad_jog_combo) begin
      jog_toggle_reg <= ~jog_toggle_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jog_mode <= 1'b0;
      jog_run <= 1'b0;
    end else begin
      jog_mode <= jog_mode_next;
      jog_run <= jog_mode_next & (keypad_mode ? keypad_run_key : (run_fwd_next | run_rev_next));
    end
  end

  combo_term_a: assert property ((!keypad_mode || inch_fs[0]) && keypad_jog_combo |=> $stable(jog_toggle_reg))
    else $error("combination acted while ignored");
  combo_toggle_a: assert property (keypad_mode && !inch_fs[0] && keypad_jog_combo |=> !$stable(jog_toggle_reg))
    else $error("combination did not toggle jog readiness");

  // ==========================================================
  // Output terminals
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transistor_output <= 1'b0;
      relay_output <= 1'b0;
    end else begin
      transistor_output <= out_select(out_assign_reg[`OUT_TR_CODE_LSB +: 7], moving_reg, match_reg, alarm_output)
                           ^ out_assign_reg[`OUT_TR_NEG_BIT];
      relay_output <= out_select(out_assign_reg[`OUT_RL_CODE_LSB +: 7], moving_reg, match_reg, alarm_output)
                      ^ out_assign_reg[`OUT_RL_NEG_BIT];
    end
  end

  relay_polarity_a: assert property (out_assign_reg[14:8] == `OUT_CODE_ALARM && alarm_output
    && $stable(out_assign_reg) |=> relay_output != out_assign_reg[`OUT_RL_NEG_BIT])
    else $error("relay polarity wrong on alarm");

  // ==========================================================
  // Readback words
  assign cmd_status = {15'h0, run_forward, run_reverse, decel_to_stop, output_cut, jog_mode, jog_run,
                       accel_set2_sel, freq_cmd2_sel, loop_enable, inverse_freq, loop_process_inverse,
                       comms_source_sel, loop_terms_clear, loop_integ_freeze, edit_all_permit,
                       edit_protect_only, 1'b0};
  assign drive_status = {17'h0, 8'(term_level), alarm_reg, external_equipment_alarm, moving_reg,
                         match_reg, transistor_output, relay_output};

endmodule : terminal_command_decoder

// [core/term_defines.svh]
// Offsets, field positions, reset values and function codes of the
// terminal command decoder.
// Assumes a 32-bit APB slave with byte addresses and pclk at 125 MHz.
// Summary of operation
// - Ramp-select active chooses second ramp pair
// - Three-wire latch holds momentary run commands
// - Coast stop cuts output, no alarm
// - Alarm reset clears alarm output, release clears indications
// - External fault opening while running trips alarm
// - Inch-ready prepares jog, run key or terminals
// - Keypad jog combination toggles in keypad mode unless inch-ready
// - Frequency-source choice picks command two
// - Edit permit and protect setting gate edits
// - Unassigned edit permit counts as active
// - Loop enable switches loop controller or manual
// - Inverse action flips frequency and loop sense
// - Comms choice selects link; unassigned means active
// - Integrator clear resets integral and differential
// - Integrator freeze stops integral growth
// - Forward/backward run while active, else decelerate
// - Two assignments map status to outputs
// - Relay polarity decides energise or release
// - Moving flag: above start, not braking
// - Speed match within fixed 2.5 Hz
// - Adding 1000 selects active-low terminal
`ifndef TERM_DEFINES_SVH
`define TERM_DEFINES_SVH

// ==========================================================
// Register map
`define ASSIGN_BASE_OFS 8'h00
`define CONFIG_OFS 8'h14
`define OUT_ASSIGN_OFS 8'h18
`define CMD_STATUS_OFS 8'h1C
`define DRIVE_STATUS_OFS 8'h20
`define LAST_WORD_IDX 6'h08

// ==========================================================
// Field layout
`define ASSIGN_W 11
`define NEG_LOGIC_OFFSET 11'h3E8
`define CFG_RUN_SRC_LSB 0
`define CFG_EDIT_PROTECT_BIT 2
`define CFG_PROCESS_INV_BIT 3
`define OUT_TR_CODE_LSB 0
`define OUT_TR_NEG_BIT 7
`define OUT_RL_CODE_LSB 8
`define OUT_RL_NEG_BIT 15

// ==========================================================
// Reset values
`define ASSIGN_X1_RST 11'h000
`define ASSIGN_X2_RST 11'h001
`define ASSIGN_X3_RST 11'h002
`define ASSIGN_FWD_RST 11'h062
`define ASSIGN_REV_RST 11'h063
`define CONFIG_RST 4'h0
`define OUT_ASSIGN_RST 16'h6300

// ==========================================================
// Input and output function codes
`define CODE_RAMP_SET 7'h04
`define CODE_LATCH 7'h06
`define CODE_COAST 7'h07
`define CODE_ALARM_RESET 7'h08
`define CODE_EXT_FAULT 7'h09
`define CODE_INCH 7'h0A
`define CODE_FREQ_SRC 7'h0B
`define CODE_EDIT_PERMIT 7'h13
`define CODE_LOOP_EN 7'h14
`define CODE_INVERSE 7'h15
`define CODE_COMMS 7'h18
`define CODE_INTEG_CLEAR 7'h21
`define CODE_INTEG_FREEZE 7'h22
`define CODE_FORWARD 7'h62
`define CODE_BACKWARD 7'h63
`define OUT_CODE_MOVING 7'h00
`define OUT_CODE_MATCH 7'h01
`define OUT_CODE_ALARM 7'h63
`define RUN_SRC_TERMINAL 2'h1

// ==========================================================
// Frequencies in 0.01 Hz units
`define FREQ_W 16
`define MATCH_WINDOW 16'h00FA

`endif

// [core/term_pkg.sv]
// Types shared by the terminal command decoder.
// Assumes the constants header is included alongside.
package term_pkg;

  // ==========================================================
  // Alarm sequence
  typedef enum logic [1:0] {
    ALARM_NORMAL,
    ALARM_TRIPPED,
    ALARM_RESETTING
  } alarm_state_t;

endpackage : term_pkg

// [core/pin_sync.sv]
// Three-stage synchroniser with agreement filter for terminal pins.
// Assumes pins are asynchronous to pclk; output is a clean level.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_stable
);

  // ==========================================================
  // Elaboration check
  generate
    if (WIDTH < 1) begin : bad_width
      $error("pin_sync needs at least one pin");
    end
  endgenerate

  // ==========================================================
  // Per-pin stages
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      // First stage feeds only the second; filter looks at stages two and three
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
        end else begin
          s1_reg <= pin_async[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_stable[i] <= 1'b0;
        end else if (s2_reg == s3_reg) begin
          pin_stable[i] <= s3_reg;
        end
      end
    end
  endgenerate

endmodule : pin_sync

// [bench/switch_panel.sv]
// Model of the switches wired to the five input terminals.
// Assumes the bench sets the wanted levels just after a pclk edge.
`timescale 1ns/1ps
module switch_panel (
  input wire logic pclk,
  input wire logic [4:0] want,
  output logic [4:0] terminal_pin
);
  // ==========================================================
  // Contacts
  // Contacts bounce off-edge in reality; one edge of lag stands in
  always @(posedge pclk) begin
    terminal_pin <= want;
  end
endmodule : switch_panel

// [bench/test_terminal_command_decoder.sv]
// Self-checking bench: APB set-up, terminal levels, status outputs.
// Assumes the decoder and the switch panel model are compiled first.
`timescale 1ns/1ps
module test_terminal_command_decoder;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, trip, combo, runkey, brake, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [4:0] want, pins;
  logic [15:0] ofreq, sfreq;
  logic [40:0] o;
  int err_total, num_checks, cyc;
  int codes[8] = '{4, 7, 11, 20, 21, 33, 34, 24};

  switch_panel i_switch_panel (.pclk(pclk), .want(want), .terminal_pin(pins));
  terminal_command_decoder i_terminal_command_decoder (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .terminal_pin(pins), .keypad_run_key(runkey), .keypad_jog_combo(combo),
    .protect_trip(trip), .dc_braking(brake), .output_freq(ofreq), .set_freq(sfreq),
    .start_freq(16'h0064), .accel_set2_sel(o[0]), .run_forward(o[8]), .run_reverse(o[15]),
    .decel_to_stop(o[9]), .output_cut(o[1]), .external_equipment_alarm(o[16]), .alarm_output(o[10]),
    .alarm_indication(o[11]), .restart_permit(o[17]), .jog_mode(o[18]), .jog_run(o[19]),
    .freq_cmd2_sel(o[2]), .edit_all_permit(o[12]), .edit_protect_only(o[20]), .loop_enable(o[3]),
    .inverse_freq(o[4]), .loop_process_inverse(o[21]), .comms_source_sel(o[7]), .loop_terms_clear(o[5]),
    .loop_integ_freeze(o[6]), .transistor_output(o[13]), .relay_output(o[14]));

  // ==========================================================
  // Clock, reset, timeout
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    cyc = 0;
    forever begin
      @(posedge pclk);
      cyc++;
      if (cyc == 6000) begin
        err_total++;
        print_verdict();
      end
    end
  end

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt

  // One APB transfer; data and error taken at the pready edge, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    chk(n, 1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // Tests
  initial begin
    err_total = 0;
    num_checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, trip, combo, runkey, brake} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    want = 5'h00;
    ofreq = 16'h0000;
    sfreq = 16'h0000;
    wt(3);
    presetn <= 1'b1;
    wt(2);
    chk(o[12], 1);
    chk(o[7], 1);
    apb(0, 8'h18, 0);
    chk(q, 32'h00006300);
    apb(0, 8'h24, 0);
    chk(e, 1);
    // Eight level input functions through terminal one, low then high
    foreach (codes[k]) begin
      apb(1, 8'h00, codes[k]);
      want <= 5'h00;
      wt(10);
      chk(o[k], 0);
      want <= 5'h01;
      wt(10);
      chk(o[k], 1);
      chk(o[10], 0);
    end
    apb(1, 8'h00, 32'h000003EC);
    want <= 5'h00;
    wt(10);
    chk(o[0], 1);
    want <= 5'h08;
    wt(10);
    chk(o[8], 1);
    want <= 5'h00;
    wt(10);
    chk({o[8], o[9]}, 2'h1);
    // Match on transistor, alarm on inverted relay
    apb(1, 8'h18, 32'h0000E301);
    apb(1, 8'h04, 32'h00000008);
    sfreq <= 16'h03E8;
    ofreq <= 16'h04E2;
    wt(6);
    chk({o[13], o[14]}, 2'h3);
    trip <= 1'b1;
    wt(1);
    trip <= 1'b0;
    wt(4);
    chk({o[10], o[14]}, 2'h2);
    want <= 5'h02;
    wt(10);
    chk({o[10], o[11]}, 2'h1);
    want <= 5'h00;
    wt(10);
    chk({o[11], o[14]}, 2'h1);
    // External fault on X3 while moving, cleared by reset on X2
    apb(1, 8'h08, 32'h00000009);
    wt(10);
    chk({o[16], o[1], o[10]}, 3'h7);
    want <= 5'h06;
    wt(10);
    want <= 5'h04;
    wt(10);
    chk({o[16], o[17]}, 2'h1);
    // Three-wire latch on X3 holds a momentary reverse
    apb(1, 8'h08, 32'h00000006);
    want <= 5'h14;
    wt(10);
    want <= 5'h04;
    wt(10);
    chk({o[15], o[8]}, 2'h2);
    want <= 5'h00;
    wt(10);
    chk(o[15], 0);
    // Keypad jog toggle, then terminal mode ignores it
    combo <= 1'b1;
    wt(1);
    combo <= 1'b0;
    runkey <= 1'b1;
    wt(4);
    chk({o[18], o[19]}, 2'h3);
    apb(1, 8'h14, 32'h0000000D);
    apb(1, 8'h00, 32'h000003FC);
    combo <= 1'b1;
    wt(1);
    combo <= 1'b0;
    wt(4);
    chk({o[18], o[12], o[20], o[21]}, 4'h3);
    apb(1, 8'h14, 32'h00000000);
    wt(2);
    chk(o[18], 1);
    // Braking drops the moving flag
    brake <= 1'b1;
    wt(2);
    apb(0, 8'h20, 0);
    chk(q[3], 0);
    brake <= 1'b0;
    wt(2);
    apb(0, 8'h20, 0);
    chk(q[3], 1);
    print_verdict();
  end
endmodule : test_terminal_command_decoder
